// ===== rtl/fcb_pkg.sv
// package for the flag conditional branch unit
package fcb_pkg;
   localparam int PC_W = 21;
   localparam logic [3:0] OPC_HI = 4'hE;
   localparam logic [3:0] OPC_NN = 4'h7;
   localparam logic [3:0] OPC_NOV = 4'h5;
   localparam logic [3:0] OPC_NZ = 4'h1;
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;
   localparam logic [PC_W-1:0] WORD_BYTES = 21'h000002;
   localparam logic [1:0] Q_RST = 2'h0;
   localparam logic [7:0] OFF_RST = 8'h00;

   // four phases of one instruction cycle, gray coded
   typedef enum logic [1:0]
   {
      Q1 = 2'b00,
      Q2 = 2'b01,
      Q3 = 2'b11,
      Q4 = 2'b10
   } fcb_q_t;

   typedef enum logic [1:0]
   {
      SEL_NONE = 2'b00,
      SEL_NN = 2'b01,
      SEL_NOV = 2'b11,
      SEL_NZ = 2'b10
   } fcb_sel_t;

   typedef struct packed
   {
      logic negative;
      logic overflow;
      logic zero;
   } fcb_flags_t;

   typedef struct packed
   {
      logic [7:0] opcode;
      logic [7:0] offset;
   } fcb_instr_t;
endpackage : fcb_pkg

// ===== rtl/fcb_branch_unit.sv
// conditional branch unit: not-negative, not-overflow, not-zero
`timescale 1ns/1ps
`default_nettype none

// Contract
// - not-negative branch taken: PC+2+2n
// - not-overflow decoded from E then 5
// - not-overflow branch taken: PC+2+2n
// - flag set: continue at PC+2
// - not-zero decoded E then 1, taken PC+2+2n
// - one word; 1 cycle, 2 if taken
// - target from incremented PC, offset doubled
module fcb_branch_unit
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire fcb_pkg::fcb_instr_t instr,
   input wire fcb_pkg::fcb_flags_t flags_in,
   output fcb_pkg::fcb_flags_t flags_out,
   output logic [fcb_pkg::PC_W-1:0] pc,
   output logic [1:0] q_phase,
   output logic is_branch,
   output logic busy
);
   import fcb_pkg::*;

   localparam int N_FLAGS = $bits(fcb_flags_t);

   // phase group
   fcb_q_t q_r, q_nxt;

   // decode group
   fcb_sel_t sel_r, sel_nxt;
   logic [7:0] off_r, off_nxt;

   // program counter group
   logic [PC_W-1:0] pc_r, pc_nxt;
   logic nop_r, nop_nxt;

   // shared combinational terms
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] target;
   logic taken;
   logic [N_FLAGS-1:0] flags_vec;
   logic [N_FLAGS-1:0] flags_pass_vec;

   // which of the three branches an opcode byte selects
   function automatic fcb_sel_t decode
   (
      input logic [7:0] op
   );
      if (op[7:4] != OPC_HI)
         decode = SEL_NONE;
      else if (op[3:0] == OPC_NN)
         decode = SEL_NN;
      else if (op[3:0] == OPC_NOV)
         decode = SEL_NOV;
      else if (op[3:0] == OPC_NZ)
         decode = SEL_NZ;
      else
         decode = SEL_NONE;
   endfunction : decode

   // a branch is taken when the flag it tests is clear
   function automatic logic flag_clear
   (
      input fcb_sel_t sel,
      input fcb_flags_t f
   );
      case (sel)
         SEL_NN: flag_clear = !f.negative;
         SEL_NOV: flag_clear = !f.overflow;
         SEL_NZ: flag_clear = !f.zero;
         default: flag_clear = 1'b0;
      endcase
   endfunction : flag_clear

   // base plus the offset sign-extended and doubled to a byte step
   function automatic logic [PC_W-1:0] branch_target
   (
      input logic [PC_W-1:0] base,
      input logic [7:0] off
   );
      logic [PC_W-1:0] disp;
      disp = {{(PC_W-9){off[7]}}, off, 1'b0};
      branch_target = base + disp;
   endfunction : branch_target

   // flags pass straight through, bit for bit
   assign flags_vec = flags_in;

   generate
      for (genvar i = 0; i < N_FLAGS; i++)
      begin : g_flag_pass
         assign flags_pass_vec[i] = flags_vec[i];
      end
   endgenerate

   assign flags_out = flags_pass_vec;

   assign pc = pc_r;
   assign q_phase = q_r;
   assign is_branch = (sel_r != SEL_NONE);
   assign busy = nop_r;

   // pc already advanced one word; target built from it
   assign pc_inc = pc_r + WORD_BYTES;
   assign target = branch_target(pc_inc, off_r);

   // flags are looked at in Q4 only, when the branch resolves
   assign taken = flag_clear(sel_r, flags_in);

   // phase sequencer: Q1 Q2 Q3 Q4, then again
   always_comb
   begin
      case (q_r)
         Q1: q_nxt = Q2;
         Q2: q_nxt = Q3;
         Q3: q_nxt = Q4;
         Q4: q_nxt = Q1;
         default: q_nxt = Q1;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         q_r <= fcb_q_t'(Q_RST);
      else
         q_r <= q_nxt;
   end

   // decode in Q1, hold through Q4, drop at the end of the cycle
   always_comb
   begin
      sel_nxt = sel_r;
      off_nxt = off_r;
      case (q_r)
         Q1:
         begin
            // decode unless this cycle is the taken branch's no-op
            if (!nop_r && instr_valid)
            begin
               sel_nxt = decode(instr.opcode);
               off_nxt = instr.offset;
            end
            else
               sel_nxt = SEL_NONE;
         end
         Q4: sel_nxt = SEL_NONE;
         default: sel_nxt = sel_r;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sel_r <= SEL_NONE;
         off_r <= OFF_RST;
      end
      else
      begin
         sel_r <= sel_nxt;
         off_r <= off_nxt;
      end
   end

   // pc is written only at the Q4 edge; a taken branch adds a no-op cycle
   always_comb
   begin
      pc_nxt = pc_r;
      nop_nxt = nop_r;
      if (q_r == Q4)
      begin
         if (nop_r)
            nop_nxt = 1'b0; // second cycle does nothing
         else if (taken)
         begin
            pc_nxt = target;
            nop_nxt = 1'b1;
         end
         else
            pc_nxt = pc_inc;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pc_r <= PC_RST;
         nop_r <= 1'b0;
      end
      else
      begin
         pc_r <= pc_nxt;
         nop_r <= nop_nxt;
      end
   end
endmodule : fcb_branch_unit

`default_nettype wire

// ===== dv/fcb_chk.sv
// checker for the branch unit
`timescale 1ns/1ps
`default_nettype none
module fcb_chk
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic is_branch,
   input wire logic busy,
   input wire fcb_pkg::fcb_instr_t instr,
   input wire fcb_pkg::fcb_flags_t flags_in,
   input wire fcb_pkg::fcb_flags_t flags_out,
   input wire logic [fcb_pkg::PC_W-1:0] pc,
   input wire logic [1:0] q_phase
);
   import fcb_pkg::*;
   logic [7:0] op;
   logic [PC_W-1:0] j;
   assign op = (q_phase == Q1 && instr_valid && !busy) ? instr.opcode : 8'h00;
   assign j = pc + WORD_BYTES
      + {{(PC_W-9){instr.offset[7]}}, instr.offset, 1'b0};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_flags_kept: assert property (flags_out == flags_in)
      else $error("flags");
   a_nn_jump: assert property (op == 8'hE7 ##3 !flags_in[2] |=>
      pc == $past(j, 4)) else $error("nn");
   a_nov_jump: assert property (op == 8'hE5 ##3 !flags_in[1] |=>
      pc == $past(j, 4)) else $error("nov");
   a_nz_jump: assert property (op == 8'hE1 ##3 !flags_in[0] |=>
      pc == $past(j, 4)) else $error("nz");
   a_set_skip: assert property (op == 8'hE5 ##3 flags_in[1] |=>
      pc == $past(pc, 4) + WORD_BYTES && !busy) else $error("skip");
   a_noop_len: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
      else $error("noop");
   a_busy_idle: assert property (busy |-> !is_branch)
      else $error("idle");
   a_phase_wrap: assert property (q_phase == Q4 |=> q_phase == Q1)
      else $error("phase");
endmodule : fcb_chk
bind fcb_branch_unit fcb_chk chk (.*);
`default_nettype wire

// ===== dv/fcb_branch_unit_test.sv
// bench for the branch unit
`timescale 1ns/1ps
`default_nettype none
module fcb_branch_unit_test;
   import fcb_pkg::*;
   logic clk_sys = 0, resetn = 0, instr_valid = 0, busy, is_branch;
   logic [1:0] q_phase;
   fcb_flags_t flags_out;
   fcb_instr_t instr = '0;
   fcb_flags_t flags_in = '0;
   logic [PC_W-1:0] pc, p;
   int num_errors = 0, n_compared = 0;
   fcb_branch_unit uut (.clk_sys(clk_sys), .resetn(resetn),
      .instr_valid(instr_valid), .instr(instr), .flags_in(flags_in),
      .flags_out(flags_out), .pc(pc), .q_phase(q_phase),
      .is_branch(is_branch), .busy(busy));
   task conclude(int e);
      num_errors += e;
      $display("%0d errors of %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   task chk(logic [31:0] a, b);
      n_compared++;
      num_errors += a !== b;
      if (a !== b) $display("Error %0t: mismatch", $time);
   endtask : chk
   task ex(logic [7:0] op, n, logic [2:0] f, logic v, t, b);
      p = pc + WORD_BYTES + 2 * t * PC_W'(signed'(n));
      {instr, flags_in, instr_valid} <= {op, n, f, v};
      @(posedge clk_sys);
      #5 chk({q_phase, is_branch}, {Q2, b});
      chk(flags_out, f);
      repeat (3) @(posedge clk_sys);
      #5 chk({busy, pc}, {t, p});
      if (t) #200;
   endtask : ex
   task t_run;
      ex(8'hE7, 8'h05, 3'h3, 1, 1, 1);
      ex(8'hE5, 8'h7F, 3'h5, 1, 1, 1);
      ex(8'hE1, 8'h80, 3'h6, 1, 1, 1);
      ex(8'hE5, 8'hFF, 3'h2, 1, 0, 1);
      ex(8'hE7, 8'h10, 3'h4, 1, 0, 1);
      ex(8'hE1, 8'h01, 3'h1, 1, 0, 1);
      ex(8'hE3, 8'h22, 3'h0, 1, 0, 0);
      ex(8'hE7, 8'h22, 3'h0, 0, 0, 0);
   endtask : t_run
   task t_reset;
      resetn = 0;
      @(posedge clk_sys);
      #5 chk({busy, is_branch, q_phase, pc}, 0);
      resetn = 1;
      ex(8'hE1, 8'h03, 3'h6, 1, 1, 1);
   endtask : t_reset
   initial forever #25 clk_sys = ~clk_sys;
   initial #20000 conclude(1);
   initial
   begin
      repeat (16) @(posedge clk_sys);
      #5 resetn = 1;
      t_run;
      t_reset;
      conclude(0);
   end
endmodule : fcb_branch_unit_test
`default_nettype wire
